/* File: design/pts_pkg.sv */
package pts_pkg;
    // ==========================================
    // Table geometry
    localparam int ENTRIES = 256;
    localparam int IDX_W = 8;
    localparam int CMD_W = 4;
    localparam int POS_W = 32;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SEL = 8'h04;
    localparam logic [7:0] OFS_TADDR = 8'h08;
    localparam logic [7:0] OFS_TCMD = 8'h0C;
    localparam logic [7:0] OFS_TPOS = 8'h10;
    localparam logic [7:0] OFS_TNEXT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_ACTPOS = 8'h1C;
    // ==========================================
    // Field positions
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_RUN = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_STEP = 3;
    localparam int CTRL_TEACH = 4;
    localparam int NEXT_VALID = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_HOLD = 1;
    localparam int ST_TEACH_OK = 2;
    localparam int ST_TEACH_REF = 3;
    localparam int ST_ENTRY = 8;
    // ==========================================
    // Reset values
    localparam logic [IDX_W-1:0] RST_IDX = 8'h00;
    localparam logic [CMD_W-1:0] RST_CMD = 4'h0;
    localparam logic [POS_W-1:0] RST_POS = 32'h0000_0000;
    // ==========================================
    // Entry command codes
    localparam logic [CMD_W-1:0] CMD_ABS_LAST = 4'h3;
    localparam logic [CMD_W-1:0] CMD_INC_LAST = 4'h7;
    localparam logic [CMD_W-1:0] CMD_ORIGIN = 4'h8;
    localparam logic [CMD_W-1:0] CMD_CLEAR = 4'h9;
    localparam logic [CMD_W-1:0] CMD_PUSH = 4'hA;
    localparam logic [CMD_W-1:0] CMD_PUSH_STOP = 4'hB;
    typedef enum logic [2:0] {
        PTS_K_ABS = 3'h0, PTS_K_INC = 3'h1, PTS_K_ORIGIN = 3'h2, PTS_K_CLEAR = 3'h3,
        PTS_K_PUSH = 3'h4, PTS_K_PUSH_STOP = 3'h5, PTS_K_INVALID = 3'h7
    } pts_kind_e;
    // Gray codes along idle, issue, run, hold
    typedef enum logic [1:0] {
        PTS_IDLE = 2'h0, PTS_ISSUE = 2'h1, PTS_RUN = 2'h3, PTS_HOLD = 2'h2
    } pts_state_e;
endpackage

/* File: design/pts_sequencer.sv */
// Operation
// [R1] Runs start from the dedicated inputs or the equivalent register command.
// [R2] Eight binary index inputs, 0 to 255, select the entry to run.
// [R3] A rising start input launches the entry currently selected.
// [R4] Controller energises the drive before asserting start.
// [R5] Normal mode runs stored entries one after another from their data.
// [R6] In normal mode a finished entry launches its next entry unprompted.
// [R7] A stop request in either mode halts and launches nothing more.
// [R8] Single step runs one entry, then holds the next waiting.
// [R9] Each step trigger in single step runs exactly the held entry.
// [R10] After a stop a newly chosen start index is accepted.
// [R11] Single step is chosen only through the register interface.
// [R12] Teaching copies actual position into the selected entry's position.
// [R13] Teaching is applied for command codes 0 to 3.
// [R14] Teaching is refused for command codes 4 to 11.
// [R15] Codes decode: 0-3 abs, 4-7 rel, 8 origin, 9 clear, 10 push, 11 stop.
// [R16] A rising teaching input stores position into the entry on the index inputs.
// [R17] An entry with an empty next field ends the run and returns idle.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pts_sequencer #(
    parameter int IDX_W = pts_pkg::IDX_W,
    parameter int POS_W = pts_pkg::POS_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller inputs
    input wire logic [IDX_W-1:0] entry_index_inputs,
    input wire logic sequence_start_input,
    input wire logic stop_input,
    input wire logic teach_input,
    // Motion engine
    input wire logic [POS_W-1:0] actual_pos,
    input wire logic motion_done,
    output logic motion_start,
    output logic motion_abort,
    output logic [IDX_W-1:0] motion_entry,
    output logic [pts_pkg::CMD_W-1:0] motion_cmd,
    output logic [2:0] motion_kind,
    output logic [POS_W-1:0] motion_target,
    // Status
    output logic seq_busy,
    output logic seq_hold
);
    // ==========================================
    // State
    typedef struct packed {
        pts_pkg::pts_state_e st;
        logic [IDX_W-1:0] entry;
        logic single;
        logic run_single;
        logic [IDX_W-1:0] sel;
        logic [IDX_W-1:0] taddr;
        logic teach_pend;
        logic [IDX_W-1:0] teach_idx;
        logic teach_ok;
        logic teach_ref;
        logic start_prev;
        logic teach_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic mstart;
        logic mabort;
        logic [IDX_W-1:0] mentry;
        logic [pts_pkg::CMD_W-1:0] mcmd;
        logic [2:0] mkind;
        logic [POS_W-1:0] mtarget;
    } pts_state_s;

    pts_state_s s;
    pts_state_s next_s;

    // Table memory, one array per field so teaching touches only positions
    logic [pts_pkg::CMD_W-1:0] cmd_mem [pts_pkg::ENTRIES];
    logic [POS_W-1:0] pos_mem [pts_pkg::ENTRIES];
    logic [IDX_W:0] nxt_mem [pts_pkg::ENTRIES];

    logic we_cmd;
    logic we_pos;
    logic we_nxt;
    logic [IDX_W-1:0] pos_addr;
    logic [POS_W-1:0] pos_wdata;

    function automatic logic [2:0] kind_of(input logic [pts_pkg::CMD_W-1:0] c);
        if (c <= pts_pkg::CMD_ABS_LAST) begin
            return pts_pkg::PTS_K_ABS;
        end else if (c <= pts_pkg::CMD_INC_LAST) begin
            return pts_pkg::PTS_K_INC;
        end
        case (c)
            pts_pkg::CMD_ORIGIN: return pts_pkg::PTS_K_ORIGIN;
            pts_pkg::CMD_CLEAR: return pts_pkg::PTS_K_CLEAR;
            pts_pkg::CMD_PUSH: return pts_pkg::PTS_K_PUSH;
            pts_pkg::CMD_PUSH_STOP: return pts_pkg::PTS_K_PUSH_STOP;
            default: return pts_pkg::PTS_K_INVALID;
        endcase
    endfunction

    // ==========================================
    // Next state
    logic apb_acc;
    logic apb_wr;
    logic hw_start;
    logic hw_teach;
    logic sw_run;
    logic sw_stop;
    logic sw_step;
    logic sw_teach;
    logic run_req;
    logic stop_req;
    logic [IDX_W-1:0] run_idx;
    logic [IDX_W:0] nxt;
    logic mapped;

    always_comb begin
        next_s = s;
        next_s.mstart = 1'b0;
        next_s.mabort = 1'b0;
        we_cmd = 1'b0;
        we_pos = 1'b0;
        we_nxt = 1'b0;
        pos_addr = s.taddr;
        pos_wdata = pwdata[POS_W-1:0];
        apb_acc = psel && penable;
        apb_wr = apb_acc && s.pready && pwrite && !s.pslverr;
        mapped = (paddr[1:0] == 2'h0) && (paddr <= pts_pkg::OFS_ACTPOS);
        sw_run = apb_wr && (paddr == pts_pkg::OFS_CTRL) && pwdata[pts_pkg::CTRL_RUN];
        sw_stop = apb_wr && (paddr == pts_pkg::OFS_CTRL) && pwdata[pts_pkg::CTRL_STOP];
        sw_step = apb_wr && (paddr == pts_pkg::OFS_CTRL) && pwdata[pts_pkg::CTRL_STEP];
        sw_teach = apb_wr && (paddr == pts_pkg::OFS_CTRL) && pwdata[pts_pkg::CTRL_TEACH];
        hw_start = sequence_start_input && !s.start_prev; // [R3]
        hw_teach = teach_input && !s.teach_prev;
        run_req = hw_start || sw_run; // [R1]
        run_idx = hw_start ? entry_index_inputs : s.sel; // [R2]
        stop_req = stop_input || sw_stop;
        nxt = nxt_mem[s.entry];
        next_s.start_prev = sequence_start_input;
        next_s.teach_prev = teach_input;

        // APB: one wait state, answer registered, writes land on the pready edge
        if (apb_acc && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !mapped;
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                pts_pkg::OFS_CTRL: next_s.prdata[pts_pkg::CTRL_SINGLE] = s.single;
                pts_pkg::OFS_SEL: next_s.prdata[IDX_W-1:0] = s.sel;
                pts_pkg::OFS_TADDR: next_s.prdata[IDX_W-1:0] = s.taddr;
                pts_pkg::OFS_TCMD: next_s.prdata[pts_pkg::CMD_W-1:0] = cmd_mem[s.taddr];
                pts_pkg::OFS_TPOS: next_s.prdata[POS_W-1:0] = pos_mem[s.taddr];
                pts_pkg::OFS_TNEXT: next_s.prdata[IDX_W:0] = nxt_mem[s.taddr];
                pts_pkg::OFS_STATUS: begin
                    next_s.prdata[pts_pkg::ST_BUSY] = (s.st != pts_pkg::PTS_IDLE);
                    next_s.prdata[pts_pkg::ST_HOLD] = (s.st == pts_pkg::PTS_HOLD);
                    next_s.prdata[pts_pkg::ST_TEACH_OK] = s.teach_ok;
                    next_s.prdata[pts_pkg::ST_TEACH_REF] = s.teach_ref;
                    next_s.prdata[pts_pkg::ST_ENTRY +: IDX_W] = s.entry;
                end
                pts_pkg::OFS_ACTPOS: next_s.prdata[POS_W-1:0] = actual_pos;
                default: next_s.prdata = 32'h0000_0000;
            endcase
        end else if (apb_acc) begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
        end
        if (apb_wr) begin
            case (paddr)
                pts_pkg::OFS_CTRL: next_s.single = pwdata[pts_pkg::CTRL_SINGLE]; // [R11]
                pts_pkg::OFS_SEL: next_s.sel = pwdata[IDX_W-1:0];
                pts_pkg::OFS_TADDR: next_s.taddr = pwdata[IDX_W-1:0];
                pts_pkg::OFS_TCMD: we_cmd = 1'b1;
                pts_pkg::OFS_TPOS: we_pos = 1'b1;
                pts_pkg::OFS_TNEXT: we_nxt = 1'b1;
                pts_pkg::OFS_STATUS: begin
                    // Write one to clear the teaching flags
                    if (pwdata[pts_pkg::ST_TEACH_OK]) begin
                        next_s.teach_ok = 1'b0;
                    end
                    if (pwdata[pts_pkg::ST_TEACH_REF]) begin
                        next_s.teach_ref = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Teaching shares the position port; a bus write there defers it a cycle
        if (s.teach_pend && !we_pos) begin
            next_s.teach_pend = 1'b0;
            if (cmd_mem[s.teach_idx] <= pts_pkg::CMD_ABS_LAST) begin // [R13]
                we_pos = 1'b1;
                pos_addr = s.teach_idx;
                pos_wdata = actual_pos; // [R12]
                next_s.teach_ok = 1'b1;
            end else begin
                next_s.teach_ref = 1'b1; // [R14]
            end
        end
        if (hw_teach) begin
            next_s.teach_pend = 1'b1;
            next_s.teach_idx = entry_index_inputs; // [R16]
        end else if (sw_teach) begin
            next_s.teach_pend = 1'b1;
            next_s.teach_idx = s.sel;
        end

        // Sequencer
        case (s.st)
            pts_pkg::PTS_IDLE: begin
                if (run_req && !stop_req) begin
                    next_s.st = pts_pkg::PTS_ISSUE;
                    next_s.entry = run_idx; // [R10]
                    // Hardware start never selects single step
                    // Mode is the one written with the run command itself
                    next_s.run_single = sw_run && pwdata[pts_pkg::CTRL_SINGLE]; // [R11]
                end
            end
            pts_pkg::PTS_ISSUE: begin
                next_s.st = pts_pkg::PTS_RUN;
                next_s.mstart = 1'b1;
                next_s.mentry = s.entry;
                next_s.mcmd = cmd_mem[s.entry];
                next_s.mkind = kind_of(cmd_mem[s.entry]); // [R15]
                next_s.mtarget = pos_mem[s.entry]; // [R5]
            end
            pts_pkg::PTS_RUN: begin
                if (motion_done) begin
                    if (!nxt[IDX_W]) begin
                        next_s.st = pts_pkg::PTS_IDLE; // [R17]
                    end else if (s.run_single) begin
                        next_s.st = pts_pkg::PTS_HOLD; // [R8]
                        next_s.entry = nxt[IDX_W-1:0];
                    end else begin
                        next_s.st = pts_pkg::PTS_ISSUE; // [R6]
                        next_s.entry = nxt[IDX_W-1:0];
                    end
                end
            end
            pts_pkg::PTS_HOLD: begin
                if (sw_step) begin
                    next_s.st = pts_pkg::PTS_ISSUE; // [R9]
                end
            end
            default: next_s.st = pts_pkg::PTS_IDLE;
        endcase
        // Stop outranks completion and steps in the same cycle
        if (stop_req && (s.st != pts_pkg::PTS_IDLE)) begin
            next_s.st = pts_pkg::PTS_IDLE; // [R7]
            next_s.mstart = 1'b0;
            next_s.mabort = 1'b1;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= pts_pkg::PTS_IDLE;
            s.sel <= pts_pkg::RST_IDX;
            s.taddr <= pts_pkg::RST_IDX;
        end else begin
            s <= next_s;
        end
    end

    // No reset on the table: contents are loaded by software after power up
    always_ff @(posedge clock) begin
        if (we_cmd) begin
            cmd_mem[s.taddr] <= pwdata[pts_pkg::CMD_W-1:0];
        end
        if (we_pos) begin
            pos_mem[pos_addr] <= pos_wdata;
        end
        if (we_nxt) begin
            nxt_mem[s.taddr] <= pwdata[IDX_W:0];
        end
    end

    // ==========================================
    // Outputs
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign motion_start = s.mstart;
    assign motion_abort = s.mabort;
    assign motion_entry = s.mentry;
    assign motion_cmd = s.mcmd;
    assign motion_kind = s.mkind;
    assign motion_target = s.mtarget;
    assign seq_busy = (s.st != pts_pkg::PTS_IDLE);
    assign seq_hold = (s.st == pts_pkg::PTS_HOLD);
endmodule
`default_nettype wire

/* File: verif/pts_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pts_sequencer_props #(
    parameter int IDX_W = 8
) (
    // Bus
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer
    input wire logic [IDX_W-1:0] entry_index_inputs,
    input wire logic sequence_start_input,
    input wire logic stop_input,
    input wire logic motion_done,
    input wire logic motion_start,
    input wire logic motion_abort,
    input wire logic [IDX_W-1:0] motion_entry,
    input wire logic seq_busy,
    input wire logic seq_hold
);
    // ====
    // Sequences
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_launch;
        $rose(sequence_start_input) && !seq_busy && !stop_input;
    endsequence
    // Past terms keep the issue cycle out, where a done is ignored
    sequence s_done_run;
        $past(seq_busy) && !$past(seq_hold) && !$past(motion_done) && seq_busy && !seq_hold
            && motion_done && !stop_input;
    endsequence
    property p_index;
        logic [IDX_W-1:0] v;
        (s_launch, v = entry_index_inputs) ##1 !stop_input |-> ##1 motion_entry == v;
    endproperty
    // ====
    // Checks
    a_start_latency: assert property (s_launch ##1 !stop_input |-> ##1 motion_start)
        else $error("start not issued two cycles after rising start");
    a_entry_index: assert property (p_index)
        else $error("issued entry differs from index inputs");
    a_chain_next: assert property (s_done_run ##1 (seq_busy && !seq_hold && !stop_input)
        |-> ##1 motion_start)
        else $error("next entry not issued after done");
    a_stop_abort: assert property (stop_input && seq_busy |=> motion_abort && !seq_busy)
        else $error("stop did not abort to idle");
    a_stop_quiet: assert property (stop_input |=> !motion_start [*2])
        else $error("entry issued after stop");
    a_hold_waits: assert property (seq_hold |-> seq_busy && !motion_start)
        else $error("entry issued while holding");
    a_apb_answer: assert property ($rose(penable) && psel |=> pready ##1 !pready)
        else $error("bus answer not a single cycle after access");
    a_apb_slverr: assert property (pready && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access not flagged");
endmodule
bind pts_sequencer pts_sequencer_props #(.IDX_W(IDX_W)) u_props (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .entry_index_inputs(entry_index_inputs),
    .sequence_start_input(sequence_start_input), .stop_input(stop_input),
    .motion_done(motion_done), .motion_start(motion_start), .motion_abort(motion_abort),
    .motion_entry(motion_entry), .seq_busy(seq_busy), .seq_hold(seq_hold)
);
`default_nettype wire

/* File: verif/pts_motion_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pts_motion_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sequencer side
    input wire logic motion_start,
    input wire logic motion_abort,
    input wire logic [31:0] motion_target,
    output logic motion_done,
    output logic servo_on,
    output logic [31:0] actual_pos
);
    int cnt;
    // ====
    // Engine, lands on target when done
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt <= 0;
            motion_done <= 1'b0;
            servo_on <= 1'b0;
            actual_pos <= 32'h0000_0000;
        end else begin
            servo_on <= 1'b1;
            motion_done <= (cnt == 1);
            if (cnt == 1) actual_pos <= motion_target;
            if (motion_abort) cnt <= 0;
            else if (motion_start) cnt <= DELAY;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

/* File: verif/pts_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pts_sequencer_tb_top;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err_seen;
    logic start_in, stop_in, teach_in, m_done, m_start, m_abort, busy, hold, servo_on;
    logic [7:0] paddr, idx, m_entry;
    logic [31:0] pwdata, prdata, rd, act_pos, m_target;
    logic [3:0] m_cmd;
    logic [2:0] m_kind;
    int errors, checks_done;
    pts_sequencer dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .entry_index_inputs(idx), .sequence_start_input(start_in), .stop_input(stop_in),
        .teach_input(teach_in), .actual_pos(act_pos), .motion_done(m_done),
        .motion_start(m_start), .motion_abort(m_abort), .motion_entry(m_entry),
        .motion_cmd(m_cmd), .motion_kind(m_kind), .motion_target(m_target),
        .seq_busy(busy), .seq_hold(hold)
    );
    pts_motion_model eng (
        .clock(clock), .rst_n(rst_n), .motion_start(m_start), .motion_abort(m_abort),
        .motion_target(m_target), .motion_done(m_done), .servo_on(servo_on),
        .actual_pos(act_pos)
    );
    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Idle cycle after each transfer so no strobe is driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic put(input logic [7:0] a, input logic [3:0] c, input logic [31:0] p,
            input logic [8:0] nx);
        apb(1'b1, pts_pkg::OFS_TADDR, {24'h0, a});
        apb(1'b1, pts_pkg::OFS_TCMD, {28'h0, c});
        apb(1'b1, pts_pkg::OFS_TPOS, p);
        apb(1'b1, pts_pkg::OFS_TNEXT, {23'h0, nx});
    endtask
    task automatic issued(input logic [7:0] e, input logic [3:0] c, input logic [2:0] k,
            input logic [31:0] t);
        int n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (m_start !== 1'b1 && n < 300);
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
        chk({24'h0, m_entry}, {24'h0, e});
        chk({28'h0, m_cmd}, {28'h0, c});
        chk({29'h0, m_kind}, {29'h0, k});
        chk(m_target, t);
        @(posedge clock);
    endtask
    // ====
    // Sequence
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        {errors, checks_done} = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata, idx, start_in, stop_in, teach_in} = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        put(8'h05, 4'h3, 32'h0000_0100, 9'h107);
        put(8'h07, 4'h4, 32'h0000_0200, 9'h1FF);
        put(8'hFF, 4'h8, 32'h0000_0300, 9'h000);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        chk({31'h0, servo_on}, 32'h1);
        idx <= 8'h05;
        start_in <= 1'b1;
        issued(8'h05, 4'h3, 3'h0, 32'h0000_0100);
        start_in <= 1'b0;
        issued(8'h07, 4'h4, 3'h1, 32'h0000_0200);
        issued(8'hFF, 4'h8, 3'h2, 32'h0000_0300);
        repeat (10) @(posedge clock);
        chk({31'h0, busy}, 32'h0);
        teach_in <= 1'b1;
        repeat (4) @(posedge clock);
        teach_in <= 1'b0;
        apb(1'b1, pts_pkg::OFS_TADDR, 32'h5);
        apb(1'b0, pts_pkg::OFS_TPOS, 32'h0);
        chk(rd, 32'h0000_0300);
        apb(1'b1, pts_pkg::OFS_SEL, 32'h2);
        for (int c = 0; c < 12; c++) begin
            put(8'h02, c[3:0], 32'h0, 9'h000);
            apb(1'b1, pts_pkg::OFS_STATUS, 32'hC);
            apb(1'b1, pts_pkg::OFS_CTRL, 32'h10);
            apb(1'b0, pts_pkg::OFS_TPOS, 32'h0);
            chk(rd, (c < 4) ? 32'h300 : 32'h0);
            apb(1'b0, pts_pkg::OFS_STATUS, 32'h0);
            chk(rd & 32'hC, (c < 4) ? 32'h4 : 32'h8);
        end
        apb(1'b1, pts_pkg::OFS_SEL, 32'h5);
        apb(1'b1, pts_pkg::OFS_CTRL, 32'h3);
        issued(8'h05, 4'h3, 3'h0, 32'h0000_0300);
        repeat (10) @(posedge clock);
        chk({30'h0, hold, busy}, 32'h3);
        apb(1'b0, pts_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'hFF00, 32'h0700);
        apb(1'b1, pts_pkg::OFS_CTRL, 32'h9);
        issued(8'h07, 4'h4, 3'h1, 32'h0000_0200);
        apb(1'b1, pts_pkg::OFS_CTRL, 32'h5);
        chk({31'h0, busy}, 32'h0);
        apb(1'b1, pts_pkg::OFS_SEL, 32'hFF);
        apb(1'b1, pts_pkg::OFS_CTRL, 32'h3);
        issued(8'hFF, 4'h8, 3'h2, 32'h0000_0300);
        repeat (10) @(posedge clock);
        start_in <= 1'b1;
        issued(8'h05, 4'h3, 3'h0, 32'h0000_0300);
        stop_in <= 1'b1;
        start_in <= 1'b0;
        repeat (2) @(posedge clock);
        stop_in <= 1'b0;
        chk({31'h0, busy}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
